/* File: hdl/ext_access_pkg.sv */
package ext_access_pkg;

	// ==========================================================
	// Special-function register map
	localparam logic [7:0] SFR_PTR0_LOW = 8'h82;
	localparam logic [7:0] SFR_PTR0_HIGH = 8'h83;
	localparam logic [7:0] SFR_PTR1_LOW = 8'h84;
	localparam logic [7:0] SFR_PTR1_HIGH = 8'h85;
	localparam logic [7:0] SFR_PTR_SEL = 8'h86;
	localparam logic [7:0] SFR_CLOCK_CTRL = 8'h8e;

	// ==========================================================
	// Field positions and reset values
	localparam int STRETCH_LSB = 0;
	localparam int STRETCH_MSB = 2;
	localparam int PTR_SEL_BIT = 0;
	localparam logic [7:0] CLOCK_CTRL_RESET = 8'h01;
	localparam logic PTR_SEL_RESET = 1'b0;
	localparam logic [15:0] PTR_RESET = 16'h0000;

	// ==========================================================
	// Timing counts, in clocks except XMOVE_BASE_MC, in machine cycles
	localparam int CNT_W = 6;
	localparam logic [1:0] MC_LAST_PHASE = 2'h3;
	localparam logic [CNT_W-1:0] CLOCKS_PER_MC = 6'h04;
	localparam logic [CNT_W-1:0] XMOVE_BASE_MC = 6'h02;
	localparam logic [CNT_W-1:0] ALE_CLOCKS = 6'h02;
	localparam logic [CNT_W-1:0] FETCH_STROBE_START = 6'h02;
	localparam logic [CNT_W-1:0] XMOVE_STROBE_START = 6'h04;
	localparam logic [CNT_W-1:0] STROBE_MIN_CLOCKS = 6'h02;

	// ==========================================================
	// Internal scratchpad
	localparam int SCRATCH_BYTES = 256;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic ale;
		logic psen_n;
		logic rd_n;
		logic wr_n;
		logic [7:0] high_addr;
	} bus_ctl_t;

	typedef struct packed {
		logic write;
		logic use_ptr;
		logic [7:0] ri_addr;
		logic [7:0] page;
		logic [7:0] wdata;
	} xmove_req_t;

	typedef struct packed {
		logic load;
		logic inc;
		logic [15:0] value;
	} ptr_op_t;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_FETCH,
		SEQ_XMOVE
	} seq_state_t;

endpackage : ext_access_pkg

/* File: hdl/pointer_bank.sv */
`timescale 1ns/1ps
`default_nettype none

module pointer_bank (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire ext_access_pkg::ptr_op_t ptr_op_i,
	output logic sel_o,
	output logic [15:0] ptr0_o,
	output logic [15:0] ptr1_o,
	output logic [15:0] active_o
);
	import ext_access_pkg::*;

	logic [15:0] ptr_q [2];
	logic sel_q;

	// ==========================================================
	// Select bit; upper bits are not stored so an increment toggles it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_q <= PTR_SEL_RESET;
		end else if (sfr_wr_i && sfr_addr_i == SFR_PTR_SEL) begin
			sel_q <= sfr_wdata_i[PTR_SEL_BIT];
		end
	end

	// ==========================================================
	// Two pointers; direct byte writes hit a fixed pointer, core ops the selected one
	for (genvar g = 0; g < 2; g++) begin : g_ptr
		localparam logic [7:0] LOW_ADDR = (g == 0) ? SFR_PTR0_LOW : SFR_PTR1_LOW;
		localparam logic [7:0] HIGH_ADDR = (g == 0) ? SFR_PTR0_HIGH : SFR_PTR1_HIGH;
		localparam logic SEL_VAL = (g == 0) ? 1'b0 : 1'b1;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				ptr_q[g] <= PTR_RESET;
			end else if (sfr_wr_i && sfr_addr_i == LOW_ADDR) begin
				ptr_q[g][7:0] <= sfr_wdata_i;
			end else if (sfr_wr_i && sfr_addr_i == HIGH_ADDR) begin
				ptr_q[g][15:8] <= sfr_wdata_i;
			end else if (sel_q == SEL_VAL && ptr_op_i.load) begin
				ptr_q[g] <= ptr_op_i.value;
			end else if (sel_q == SEL_VAL && ptr_op_i.inc) begin
				ptr_q[g] <= ptr_q[g] + 16'h0001;
			end
		end
	end

	assign sel_o = sel_q;
	assign ptr0_o = ptr_q[0];
	assign ptr1_o = ptr_q[1];
	assign active_o = ptr_q[sel_q];

endmodule : pointer_bank

`default_nettype wire

/* File: hdl/ext_data_access.sv */
`timescale 1ns/1ps
`default_nettype none

module ext_data_access (
	input wire logic clk_i,
	input wire logic rst_i,
	// Special-function register port
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_hit_o,
	// Core pointer operations
	input wire ext_access_pkg::ptr_op_t ptr_op_i,
	output logic [15:0] data_pointer_o,
	// Program fetch request
	input wire logic fetch_req_i,
	input wire logic [15:0] fetch_addr_i,
	output logic fetch_ready_o,
	output logic fetch_done_o,
	output logic [7:0] fetch_data_o,
	// External data move request
	input wire logic xmove_req_i,
	input wire ext_access_pkg::xmove_req_t xmove_i,
	output logic xmove_ready_o,
	output logic xmove_done_o,
	output logic [7:0] xmove_rdata_o,
	// Scratchpad
	input wire logic [7:0] scratch_addr_i,
	input wire logic scratch_wr_i,
	input wire logic [7:0] scratch_wdata_i,
	output logic [7:0] scratch_rdata_o,
	// Machine cycle phase for the core
	output logic [1:0] mc_phase_o,
	// Pins
	input wire logic [7:0] addr_data_port_i,
	output logic [7:0] addr_data_port_o,
	output logic addr_data_port_oe_n_o,
	output ext_access_pkg::bus_ctl_t bus_ctl_o
);
	import ext_access_pkg::*;

	// ==========================================================
	// Decode helpers
	function automatic logic is_sfr(input logic [7:0] a);
		is_sfr = (a == SFR_PTR0_LOW) || (a == SFR_PTR0_HIGH) || (a == SFR_PTR1_LOW)
			|| (a == SFR_PTR1_HIGH) || (a == SFR_PTR_SEL) || (a == SFR_CLOCK_CTRL);
	endfunction : is_sfr

	function automatic logic [CNT_W-1:0] strobe_len(input logic [2:0] s);
		strobe_len = (s == 3'h0) ? STROBE_MIN_CLOCKS : (CLOCKS_PER_MC * {3'h0, s});
	endfunction : strobe_len

	// ==========================================================
	// Clock control register
	logic [7:0] clock_ctrl_q;
	logic [2:0] stretch;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clock_ctrl_q <= CLOCK_CTRL_RESET;
		end else if (sfr_wr_i && sfr_addr_i == SFR_CLOCK_CTRL) begin
			clock_ctrl_q <= sfr_wdata_i;
		end
	end

	assign stretch = clock_ctrl_q[STRETCH_MSB:STRETCH_LSB];

	// ==========================================================
	// Data pointers
	logic ptr_sel;
	logic [15:0] ptr0;
	logic [15:0] ptr1;
	logic [15:0] ptr_active;

	pointer_bank u_pointer_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sfr_addr_i(sfr_addr_i),
		.sfr_wr_i(sfr_wr_i),
		.sfr_wdata_i(sfr_wdata_i),
		.ptr_op_i(ptr_op_i),
		.sel_o(ptr_sel),
		.ptr0_o(ptr0),
		.ptr1_o(ptr1),
		.active_o(ptr_active)
	);

	assign data_pointer_o = ptr_active;

	// ==========================================================
	// Register read mux; unmapped addresses read zero and drop the hit flag
	always_comb begin
		sfr_hit_o = is_sfr(sfr_addr_i);
		case (sfr_addr_i)
			SFR_PTR0_LOW: sfr_rdata_o = ptr0[7:0];
			SFR_PTR0_HIGH: sfr_rdata_o = ptr0[15:8];
			SFR_PTR1_LOW: sfr_rdata_o = ptr1[7:0];
			SFR_PTR1_HIGH: sfr_rdata_o = ptr1[15:8];
			SFR_PTR_SEL: sfr_rdata_o = {7'h00, ptr_sel};
			SFR_CLOCK_CTRL: sfr_rdata_o = clock_ctrl_q;
			default: sfr_rdata_o = 8'h00;
		endcase
	end

	// ==========================================================
	// Scratchpad, the only on-chip memory; program space is all off-chip
	logic [7:0] scratch_q [SCRATCH_BYTES];
	logic [7:0] scratch_rdata_q;

	always_ff @(posedge clk_i) begin
		if (scratch_wr_i) begin
			scratch_q[scratch_addr_i] <= scratch_wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scratch_rdata_q <= 8'h00;
		end else begin
			scratch_rdata_q <= scratch_q[scratch_addr_i];
		end
	end

	assign scratch_rdata_o = scratch_rdata_q;

	// ==========================================================
	// Free-running machine cycle phase
	logic [1:0] phase_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	assign mc_phase_o = phase_q;

	// ==========================================================
	// Bus sequencer
	seq_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] len_q;
	logic [CNT_W-1:0] strobe_start_q;
	logic [CNT_W-1:0] strobe_end_q;
	logic [15:0] addr_q;
	logic [7:0] wdata_q;
	logic write_q;
	logic last_clk;
	logic seq_free;
	logic take_xmove;
	logic take_fetch;

	assign last_clk = (state_q != SEQ_IDLE) && (cnt_q == len_q - 6'h01);
	// New work only starts on a machine cycle boundary, so every access is whole cycles
	assign seq_free = ((state_q == SEQ_IDLE) || last_clk) && (phase_q == MC_LAST_PHASE);
	assign xmove_ready_o = seq_free;
	assign fetch_ready_o = seq_free && !xmove_req_i;
	assign take_xmove = seq_free && xmove_req_i;
	assign take_fetch = seq_free && fetch_req_i && !xmove_req_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= SEQ_IDLE;
			cnt_q <= 6'h00;
			len_q <= CLOCKS_PER_MC;
			strobe_start_q <= FETCH_STROBE_START;
			strobe_end_q <= CLOCKS_PER_MC;
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
			write_q <= 1'b0;
		end else if (take_xmove) begin
			state_q <= SEQ_XMOVE;
			cnt_q <= 6'h00;
			// Stretch is sampled once here, so a rewrite mid-move waits for the next one
			len_q <= CLOCKS_PER_MC * ({3'h0, stretch} + XMOVE_BASE_MC);
			strobe_start_q <= XMOVE_STROBE_START;
			strobe_end_q <= XMOVE_STROBE_START + strobe_len(stretch);
			addr_q <= xmove_i.use_ptr ? ptr_active : {xmove_i.page, xmove_i.ri_addr};
			wdata_q <= xmove_i.wdata;
			write_q <= xmove_i.write;
		end else if (take_fetch) begin
			state_q <= SEQ_FETCH;
			cnt_q <= 6'h00;
			len_q <= CLOCKS_PER_MC;
			strobe_start_q <= FETCH_STROBE_START;
			strobe_end_q <= CLOCKS_PER_MC;
			addr_q <= fetch_addr_i;
			write_q <= 1'b0;
		end else if (last_clk) begin
			state_q <= SEQ_IDLE;
			cnt_q <= 6'h00;
		end else if (state_q != SEQ_IDLE) begin
			cnt_q <= cnt_q + 6'h01;
		end
	end

	// ==========================================================
	// Pin drive, registered one clock behind the sequencer
	logic in_strobe;
	logic in_ale;
	bus_ctl_t bus_q;
	logic [7:0] port_out_q;
	logic port_oe_n_q;

	assign in_strobe = (state_q != SEQ_IDLE) && (cnt_q >= strobe_start_q) && (cnt_q < strobe_end_q);
	assign in_ale = (state_q != SEQ_IDLE) && (cnt_q < ALE_CLOCKS);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_q <= '{ale: 1'b0, psen_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, high_addr: 8'h00};
		end else begin
			bus_q.ale <= in_ale;
			bus_q.psen_n <= !(in_strobe && state_q == SEQ_FETCH);
			bus_q.rd_n <= !(in_strobe && state_q == SEQ_XMOVE && !write_q);
			bus_q.wr_n <= !(in_strobe && state_q == SEQ_XMOVE && write_q);
			if (state_q != SEQ_IDLE) begin
				bus_q.high_addr <= addr_q[15:8];
			end
		end
	end

	// Low address goes out under the latch pulse, then the port carries write data or floats
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_out_q <= 8'h00;
			port_oe_n_q <= 1'b1;
		end else if (in_ale) begin
			port_out_q <= addr_q[7:0];
			port_oe_n_q <= 1'b0;
		end else if (state_q == SEQ_XMOVE && write_q && cnt_q <= strobe_end_q) begin
			port_out_q <= wdata_q;
			port_oe_n_q <= 1'b0;
		end else begin
			port_oe_n_q <= 1'b1;
		end
	end

	assign bus_ctl_o = bus_q;
	assign addr_data_port_o = port_out_q;
	assign addr_data_port_oe_n_o = port_oe_n_q;

	// ==========================================================
	// Read capture; pin data passes two flops, so sampling trails the strobe by two clocks
	logic [7:0] port_meta_q;
	logic [7:0] port_sync_q;
	logic [1:0] cap_arm_q;
	logic [1:0] cap_kind_q;
	logic cap_arm;
	logic [7:0] fetch_data_q;
	logic [7:0] xmove_rdata_q;
	logic fetch_done_q;
	logic xmove_done_q;

	assign cap_arm = in_strobe && (cnt_q == strobe_end_q - 6'h01) && !write_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_meta_q <= 8'h00;
			port_sync_q <= 8'h00;
		end else begin
			port_meta_q <= addr_data_port_i;
			port_sync_q <= port_meta_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_arm_q <= 2'h0;
			cap_kind_q <= 2'h0;
		end else begin
			cap_arm_q <= {cap_arm_q[0], cap_arm};
			cap_kind_q <= {cap_kind_q[0], state_q == SEQ_XMOVE};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fetch_data_q <= 8'h00;
			xmove_rdata_q <= 8'h00;
			fetch_done_q <= 1'b0;
			xmove_done_q <= 1'b0;
		end else begin
			fetch_done_q <= cap_arm_q[1] && !cap_kind_q[1];
			xmove_done_q <= (cap_arm_q[1] && cap_kind_q[1]) || (last_clk && state_q == SEQ_XMOVE && write_q);
			if (cap_arm_q[1] && !cap_kind_q[1]) begin
				fetch_data_q <= port_sync_q;
			end
			if (cap_arm_q[1] && cap_kind_q[1]) begin
				xmove_rdata_q <= port_sync_q;
			end
		end
	end

	assign fetch_done_o = fetch_done_q;
	assign fetch_data_o = fetch_data_q;
	assign xmove_done_o = xmove_done_q;
	assign xmove_rdata_o = xmove_rdata_q;

endmodule : ext_data_access

`default_nettype wire

/* File: tb/ext_sram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Off-chip memory, shared by data moves and program fetches
module ext_sram_model (
	input wire logic clk_i,
	input wire ext_access_pkg::bus_ctl_t ctl_i,
	input wire logic [7:0] port_i,
	output logic [7:0] data_o
);
	import ext_access_pkg::*;
	logic [7:0] mem_q [0:65535];
	logic [15:0] addr_q;
	logic [7:0] last_q = 8'h00;
	logic drive;
	assign drive = !ctl_i.rd_n || !ctl_i.psen_n;
	// Released bus changes every cycle, so a capture one clock late never sees a stale byte
	assign data_o = drive ? mem_q[addr_q] : ~last_q;
	always_ff @(posedge clk_i) begin
		last_q <= data_o;
		if (ctl_i.ale) begin
			addr_q <= {ctl_i.high_addr, port_i};
		end
		if (!ctl_i.wr_n) begin
			mem_q[addr_q] <= port_i;
		end
	end
endmodule : ext_sram_model
`default_nettype wire

/* File: tb/ext_data_access_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bus and register checker
module ext_data_access_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire ext_access_pkg::ptr_op_t ptr_op_i,
	input wire logic [15:0] data_pointer_o,
	input wire logic fetch_req_i,
	input wire logic fetch_ready_o,
	input wire logic xmove_req_i,
	input wire logic xmove_ready_o,
	input wire logic [1:0] mc_phase_o,
	input wire logic addr_data_port_oe_n_o,
	input wire ext_access_pkg::bus_ctl_t bus_ctl_o
);
	import ext_access_pkg::*;
	logic [2:0] stretch_q;
	logic [5:0] low_q, wid_q, since_q, len_q;
	logic busy_q, take;
	assign take = xmove_req_i && xmove_ready_o;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ==========
	// Stretch shadow; the move keeps the value seen when it was taken
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stretch_q <= 3'h1;
		end else if (sfr_wr_i && sfr_addr_i == 8'h8e) begin
			stretch_q <= sfr_wdata_i[2:0];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || (bus_ctl_o.rd_n && bus_ctl_o.wr_n)) begin
			low_q <= 6'h00;
		end else begin
			low_q <= low_q + 6'h01;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_q <= 1'b0;
			since_q <= 6'h00;
			len_q <= 6'h00;
			wid_q <= 6'h00;
		end else if (take) begin
			busy_q <= 1'b1;
			since_q <= 6'h01;
			len_q <= {1'b0, stretch_q, 2'b00} + 6'h08;
			wid_q <= (stretch_q == 3'h0) ? 6'h02 : {1'b0, stretch_q, 2'b00};
		end else if (since_q == len_q) begin
			busy_q <= 1'b0;
		end else begin
			since_q <= since_q + 6'h01;
		end
	end
	// ==========
	// Properties
	property p_phase_step;
		!$past(rst_i) |-> mc_phase_o == $past(mc_phase_o) + 2'h1;
	endproperty
	a_phase_step: assert property (p_phase_step) else $error("phase did not step");
	property p_strobe_width;
		$rose(bus_ctl_o.rd_n && bus_ctl_o.wr_n) |-> low_q == wid_q;
	endproperty
	a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");
	property p_move_len;
		busy_q && xmove_ready_o |-> since_q == len_q;
	endproperty
	a_move_len: assert property (p_move_len) else $error("move ended early");
	property p_move_end;
		busy_q && since_q == len_q |-> xmove_ready_o;
	endproperty
	a_move_end: assert property (p_move_end) else $error("move ended late");
	property p_fetch_len;
		fetch_req_i && fetch_ready_o && !xmove_req_i |=> !fetch_ready_o [*3] ##1 fetch_ready_o;
	endproperty
	a_fetch_len: assert property (p_fetch_len) else $error("fetch not one cycle");
	property p_psen_width;
		$fell(bus_ctl_o.psen_n) |=> !bus_ctl_o.psen_n ##1 bus_ctl_o.psen_n;
	endproperty
	a_psen_width: assert property (p_psen_width) else $error("fetch strobe width wrong");
	property p_sel_zero;
		sfr_addr_i == 8'h86 |-> sfr_rdata_o[7:1] == 7'h00;
	endproperty
	a_sel_zero: assert property (p_sel_zero) else $error("select upper bits set");
	property p_load;
		ptr_op_i.load && !sfr_wr_i |=> data_pointer_o == $past(ptr_op_i.value);
	endproperty
	a_load: assert property (p_load) else $error("pointer load lost");
	property p_wr_drive;
		!bus_ctl_o.wr_n |-> !addr_data_port_oe_n_o;
	endproperty
	a_wr_drive: assert property (p_wr_drive) else $error("port not driven in write");
endmodule : ext_data_access_chk
bind ext_data_access ext_data_access_chk ext_data_access_chk_i (
	.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
	.sfr_rdata_o(sfr_rdata_o), .ptr_op_i(ptr_op_i), .data_pointer_o(data_pointer_o), .fetch_req_i(fetch_req_i),
	.fetch_ready_o(fetch_ready_o), .xmove_req_i(xmove_req_i), .xmove_ready_o(xmove_ready_o),
	.mc_phase_o(mc_phase_o), .addr_data_port_oe_n_o(addr_data_port_oe_n_o), .bus_ctl_o(bus_ctl_o)
);
`default_nettype wire

/* File: tb/tb_ext_data_access.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_ext_data_access;
	import ext_access_pkg::*;
	logic clk_i, rst_i, sfr_wr_i, sfr_hit_o, fetch_req_i, fetch_ready_o, fetch_done_o;
	logic xmove_req_i, xmove_ready_o, xmove_done_o, scratch_wr_i, oe_n;
	logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, fetch_data_o, xmove_rdata_o;
	logic [7:0] scratch_addr_i, scratch_wdata_i, scratch_rdata_o, port_in, port_out;
	logic [15:0] fetch_addr_i, data_pointer_o;
	logic [1:0] mc_phase_o;
	ptr_op_t ptr_op_i;
	xmove_req_t xmove_i;
	bus_ctl_t bus_ctl;
	int mismatches = 0, num_checks = 0, c0, c7;
	ext_data_access ext_data_access_i (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
		.sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
		.ptr_op_i(ptr_op_i), .data_pointer_o(data_pointer_o), .fetch_req_i(fetch_req_i),
		.fetch_addr_i(fetch_addr_i), .fetch_ready_o(fetch_ready_o), .fetch_done_o(fetch_done_o),
		.fetch_data_o(fetch_data_o), .xmove_req_i(xmove_req_i), .xmove_i(xmove_i),
		.xmove_ready_o(xmove_ready_o), .xmove_done_o(xmove_done_o), .xmove_rdata_o(xmove_rdata_o),
		.scratch_addr_i(scratch_addr_i), .scratch_wr_i(scratch_wr_i), .scratch_wdata_i(scratch_wdata_i),
		.scratch_rdata_o(scratch_rdata_o), .mc_phase_o(mc_phase_o), .addr_data_port_i(port_in),
		.addr_data_port_o(port_out), .addr_data_port_oe_n_o(oe_n), .bus_ctl_o(bus_ctl));
	ext_sram_model ext_sram_model_i (.clk_i(clk_i), .ctl_i(bus_ctl), .port_i(port_out), .data_o(port_in));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// ==========
	// Tasks
	task automatic finish_test;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic step(inout int n);
		n++;
		if (n > 100) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, n, 100);
			finish_test();
		end else begin
			@(posedge clk_i);
		end
	endtask : step
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		sfr_wr_i <= 1'b1;
		@(posedge clk_i);
		sfr_wr_i <= 1'b0;
		@(posedge clk_i);
	endtask : sfr_wr
	task automatic sfr_chk(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr_i <= a;
		@(posedge clk_i);
		check({8'h00, sfr_rdata_o}, {8'h00, exp});
	endtask : sfr_chk
	task automatic ptr(input logic ld, input logic [15:0] v);
		ptr_op_i <= '{load: ld, inc: !ld, value: v};
		@(posedge clk_i);
		ptr_op_i <= '0;
		@(posedge clk_i);
	endtask : ptr
	// For a read, d is the expected byte; ns other than ff rewrites the stretch mid-move
	task automatic xmove(input logic wr, input logic up, input logic [15:0] a, input logic [7:0] d,
		input logic [7:0] ns);
		int n;
		n = 0;
		xmove_i <= '{write: wr, use_ptr: up, ri_addr: a[7:0], page: a[15:8], wdata: d};
		xmove_req_i <= 1'b1;
		@(posedge clk_i);
		while (xmove_ready_o !== 1'b1) step(n);
		xmove_req_i <= 1'b0;
		if (ns != 8'hff) sfr_wr(8'h8e, ns);
		while (xmove_done_o !== 1'b1) step(n);
		if (!wr) check({8'h00, xmove_rdata_o}, {8'h00, d});
	endtask : xmove
	task automatic fetch(input logic [15:0] a, input logic [7:0] exp, output int cyc);
		int n;
		n = 0;
		cyc = 0;
		fetch_addr_i <= a;
		fetch_req_i <= 1'b1;
		@(posedge clk_i);
		while (fetch_ready_o !== 1'b1) step(n);
		fetch_req_i <= 1'b0;
		while (fetch_done_o !== 1'b1) step(cyc);
		check({8'h00, fetch_data_o}, {8'h00, exp});
	endtask : fetch
	// ==========
	// Main sequence
	initial begin
		rst_i = 1'b1;
		{sfr_wr_i, fetch_req_i, xmove_req_i, scratch_wr_i} = 4'h0;
		{sfr_addr_i, sfr_wdata_i, scratch_addr_i, scratch_wdata_i} = 32'h0;
		fetch_addr_i = 16'h0000;
		ptr_op_i = '0;
		xmove_i = '0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		sfr_chk(8'h8e, 8'h01);
		sfr_chk(8'h86, 8'h00);
		check({15'h0000, sfr_hit_o}, 16'h0001);
		sfr_chk(8'h90, 8'h00);
		check({15'h0000, sfr_hit_o}, 16'h0000);
		for (logic [7:0] a = 8'h82; a < 8'h86; a++) sfr_wr(a, {a[3:0], a[3:0]});
		for (logic [7:0] a = 8'h82; a < 8'h86; a++) sfr_chk(a, {a[3:0], a[3:0]});
		check(data_pointer_o, 16'h3322);
		sfr_wr(8'h86, 8'hff);
		sfr_chk(8'h86, 8'h01);
		check(data_pointer_o, 16'h5544);
		sfr_wr(8'h86, 8'h02);
		check(data_pointer_o, 16'h3322);
		sfr_wr(8'h86, 8'h01);
		ptr(1'b1, 16'h12ff);
		ptr(1'b0, 16'h0000);
		check(data_pointer_o, 16'h1300);
		sfr_chk(8'h85, 8'h13);
		sfr_chk(8'h83, 8'h33);
		// Write through the pointer, read back by page and low address
		for (logic [3:0] s = 4'h0; s < 4'h8; s++) begin
			sfr_wr(8'h8e, {5'h00, s[2:0]});
			sfr_chk(8'h8e, {5'h00, s[2:0]});
			ptr(1'b1, {8'h5a, 5'h00, s[2:0]});
			xmove(1'b1, 1'b1, 16'h0000, {5'h18, s[2:0]}, 8'hff);
			xmove(1'b0, 1'b0, {8'h5a, 5'h00, s[2:0]}, {5'h18, s[2:0]}, 8'hff);
		end
		xmove(1'b0, 1'b1, 16'h0000, 8'hc7, 8'h00);
		xmove(1'b0, 1'b0, 16'h5a06, 8'hc6, 8'hff);
		sfr_chk(8'h8e, 8'h00);
		fetch(16'h5a03, 8'hc3, c0);
		sfr_wr(8'h8e, 8'h07);
		fetch(16'h5a03, 8'hc3, c7);
		check(c7[15:0], c0[15:0]);
		// Scratchpad read data lags its address by one clock
		scratch_wr_i <= 1'b1;
		scratch_addr_i <= 8'hff;
		scratch_wdata_i <= 8'h3c;
		@(posedge clk_i);
		scratch_addr_i <= 8'h00;
		scratch_wdata_i <= 8'hc3;
		@(posedge clk_i);
		scratch_wr_i <= 1'b0;
		scratch_addr_i <= 8'hff;
		@(posedge clk_i);
		scratch_addr_i <= 8'h00;
		@(posedge clk_i);
		check({8'h00, scratch_rdata_o}, 16'h003c);
		@(posedge clk_i);
		check({8'h00, scratch_rdata_o}, 16'h00c3);
		finish_test();
	end
endmodule : tb_ext_data_access
`default_nettype wire
